// file: verilog/pvob_bridge.sv
// Purpose: outbound window decode and map lookup of a pci to vme bridge
// Assumes: inputs synchronous to sys_clk; one access at a time
// Notes: a request is held until done pulses
//
// Overview of operation
// - base registers reached by config cycles only
// - csr base writable in bits 31..9
// - csr base low nine bits read zero
// - large base writable in bits 31..29
// - strap high 512M, low 256M window
// - map base places 128K entry region
// - two-pin strap sizes small window, 8M to 64M
// - size register reports strap code
// - 512M large window has 2048 pages 256K
// - entry n serves page n both windows
// - entries keep upper 27 bits only
// - window hit triggers lookup first
// - address bits pick entry and offset
// - invalid entry sets error, no cycle
// - error interrupt only when enabled
// - valid entry starts vme access
// - modifier from size and function fields
// - pages map to a32, a24, a16
// - master issues a16, a24, a32
// - size codes select modifier table
`include "pvob_regs.svh"
`default_nettype none
module pvob_bridge
	import pvob_pkg::*;
#(
	parameter int PAGES = 2048,  // map entries
	parameter int IDX_W = 11     // entry index width
)(
	input  wire logic        sys_clk,       // 40 MHz clock
	input  wire logic        reset,         // sync reset, high
	input  wire logic        large_strap,   // 1: 512M, 0: 256M
	input  wire logic [1:0]  small_strap,   // small window size pins
	input  wire logic        cfg_req,       // config cycle strobe
	input  wire logic        cfg_wr,        // 1 write, 0 read
	input  wire logic [11:0] cfg_addr,      // config byte offset
	input  wire logic [31:0] cfg_wdata,     // config write data
	output logic             cfg_ack,       // config answer pulse
	output logic      [31:0] cfg_rdata,     // config read data
	input  wire logic        mem_req,       // memory cycle, held
	input  wire logic        mem_wr,        // 1 write, 0 read
	input  wire logic [31:0] mem_addr,      // pci memory address
	input  wire logic [3:0]  mem_be_n,      // byte enables, low
	input  wire logic [31:0] mem_wdata,     // memory write data
	output logic             mem_done,      // memory answer pulse
	output logic      [31:0] mem_rdata,     // map entry read data
	output logic             mem_hit,       // address claimed
	input  wire logic [5:0]  user_am,       // user modifier register
	input  wire logic        err_int_en,    // interrupt enable bit
	input  wire logic        err_clr,       // clears error flag
	output logic             err_flag,      // bus error status bit
	output logic             err_irq,       // bridge interrupt
	output logic             vme_start,     // vme master start pulse
	output logic      [31:0] vme_addr,      // vme address
	output logic      [5:0]  vme_am,        // address modifier
	output logic      [1:0]  vme_asize,     // address size field
	output logic      [1:0]  vme_fcode,     // function code field
	output logic      [3:0]  vme_be_n,      // byte lanes, low
	output logic             vme_write,     // vme direction
	output logic      [31:0] vme_wdata,     // vme write data
	input  wire logic        vme_done       // vme cycle complete
);
	// ----------------------------------------
	// registers and wiring
	// ----------------------------------------
	logic [31:0] csr_window_base_r;        // control window base
	logic [31:0] large_vme_window_base_r;  // large window base
	logic [31:0] map_ram_window_base_r;    // entry region base
	logic [31:0] small_vme_window_base_r;  // small window base
	logic [31:0] large_mask;               // large window size bits
	logic [31:0] small_mask;               // small window size bits
	logic [2:0]  small_code;               // size code
	logic [IDX_W-1:0] idx;                 // selected entry
	logic        hit_large;                // large window hit
	logic        hit_small;                // small window hit
	logic        hit_map;                  // map region hit
	logic        err_flag_r;               // sticky error
	logic        idle_r;                   // in idle state
	pvob_state_t state_r;                  // lookup state
	pvob_state_t state_nxt;                // next state
	pvob_map_if #(.IDX_W(IDX_W)) map ();   // map storage link

	// window match under a mask
	function automatic logic win_hit(input logic [31:0] a, input logic [31:0] b, input logic [31:0] mk);
		win_hit = ((a & mk) == (b & mk)) && (mk != 32'h00000000);
	endfunction : win_hit

	// modifier from size and function fields
	function automatic logic [5:0] am_of(input logic [1:0] az, input logic [1:0] fc, input logic [5:0] ua);
		logic [5:0] base;
		base = `PVOB_AM_A32;
		case (az)
			`PVOB_ADDRESS_SIZE_FIELD_A32: base = `PVOB_AM_A32;
			`PVOB_ADDRESS_SIZE_FIELD_A24: base = `PVOB_AM_A24;
			`PVOB_ADDRESS_SIZE_FIELD_A16: base = `PVOB_AM_A16;
			default:        base = ua;
		endcase
		if (az == `PVOB_ADDRESS_SIZE_FIELD_USER) begin
			am_of = ua;
		end else if (az == `PVOB_ADDRESS_SIZE_FIELD_A16) begin
			// a16 has no program space, only supervisor bit
			am_of = base | {3'h0, fc[1], 2'h0};
		end else begin
			// fc[1] supervisor adds 4, fc[0] program adds 1
			am_of = base + {3'h0, fc[1], 1'b0, fc[0]};
		end
	endfunction : am_of

	// ----------------------------------------
	// strap decode
	// ----------------------------------------
	// large window size
	assign large_mask = large_strap ? `PVOB_LARGE512_MASK : `PVOB_LARGE256_MASK;
	always_comb begin
		case (small_strap)
			2'h3:    begin small_mask = `PVOB_SMALL64_MASK; small_code = `PVOB_SZ_64M; end
			2'h2:    begin small_mask = `PVOB_SMALL32_MASK; small_code = `PVOB_SZ_32M; end
			2'h1:    begin small_mask = `PVOB_SMALL16_MASK; small_code = `PVOB_SZ_16M; end
			default: begin small_mask = `PVOB_SMALL8_MASK;  small_code = `PVOB_SZ_8M;  end
		endcase
	end

	// ----------------------------------------
	// configuration register file
	// ----------------------------------------
	// only config cycles reach these, memory cycles never do
	// config access only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			csr_window_base_r       <= `PVOB_BASE_RST;
			large_vme_window_base_r <= `PVOB_BASE_RST;
			map_ram_window_base_r   <= `PVOB_BASE_RST;
			small_vme_window_base_r <= `PVOB_BASE_RST;
		end else if (cfg_req && cfg_wr) begin
			case (cfg_addr)
				`PVOB_OFS_CSR_BASE:   csr_window_base_r <= cfg_wdata & `PVOB_CSR_MASK;
				`PVOB_OFS_LARGE_BASE: large_vme_window_base_r <= cfg_wdata & `PVOB_LARGE512_MASK;
				`PVOB_OFS_MAP_BASE:   map_ram_window_base_r <= cfg_wdata & `PVOB_MAP_MASK;
				`PVOB_OFS_SMALL_BASE: small_vme_window_base_r <= cfg_wdata & `PVOB_SMALL64_MASK;
				default: ;
			endcase
		end
	end

	// config answer, one cycle after the strobe
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cfg_ack   <= 1'b0;
			cfg_rdata <= 32'h00000000;
		end else begin
			cfg_ack   <= cfg_req;
			cfg_rdata <= 32'h00000000;
			if (cfg_req && !cfg_wr) begin
				case (cfg_addr)
					`PVOB_OFS_CSR_BASE:   cfg_rdata <= csr_window_base_r & `PVOB_CSR_MASK;
					`PVOB_OFS_LARGE_BASE: cfg_rdata <= large_vme_window_base_r & large_mask;
					`PVOB_OFS_MAP_BASE:   cfg_rdata <= map_ram_window_base_r;
					`PVOB_OFS_SMALL_BASE: cfg_rdata <= small_vme_window_base_r & small_mask;
					`PVOB_OFS_SMALL_SIZE: cfg_rdata <= {29'h0, small_code};
					default:              cfg_rdata <= 32'h00000000;
				endcase
			end
		end
	end

	// ----------------------------------------
	// memory decode
	// ----------------------------------------
	// window hit
	assign hit_large = win_hit(mem_addr, large_vme_window_base_r, large_mask);
	assign hit_small = win_hit(mem_addr, small_vme_window_base_r, small_mask);
	assign hit_map   = win_hit(mem_addr, map_ram_window_base_r, `PVOB_MAP_MASK);
	assign mem_hit   = mem_req && (hit_large || hit_small || hit_map);
	// entry select bits
	// offset within the window only: base bits above its size are cleared, so small page n uses entry n
	assign idx = hit_map   ? mem_addr[IDX_W+1:2] :
	             hit_small ? (mem_addr[IDX_W+17:18] & ~small_mask[IDX_W+17:18]) :
	                         (mem_addr[IDX_W+17:18] & ~large_mask[IDX_W+17:18]);

	// entry writes through the map region
	// entry region access
	// a request still held while its answer shows is not taken a second time
	assign map.we    = idle_r && mem_req && hit_map && mem_wr && !mem_done;
	assign map.widx  = idx;
	assign map.wdata = mem_wdata;
	assign map.ridx  = idx;
	assign idle_r    = (state_r == PVOB_IDLE);

	pvob_map_ram #(.DEPTH(PAGES), .IDX_W(IDX_W)) u_map (
		.sys_clk (sys_clk),
		.reset   (reset),
		.m       (map.mem)
	);

	// ----------------------------------------
	// lookup state machine
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			PVOB_IDLE: begin
				// master drops the request at the edge that sees mem_done, so skip that cycle
				if (mem_req && !mem_done && (hit_large || hit_small || (hit_map && !mem_wr))) begin
					state_nxt = PVOB_LOOK;
				end
			end
			PVOB_LOOK: begin
				if (hit_map) begin
					state_nxt = PVOB_IDLE;
				end else if (!map.rdata[`PVOB_ENT_VALID]) begin
					state_nxt = PVOB_ERR;
				end else begin
					state_nxt = PVOB_VME;
				end
			end
			PVOB_VME: begin
				if (vme_done) begin
					state_nxt = PVOB_IDLE;
				end
			end
			PVOB_ERR:  state_nxt = PVOB_IDLE;
			default:   state_nxt = PVOB_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (reset) begin
			state_r <= PVOB_IDLE;
		end else begin
			state_r <= state_nxt;
		end
	end

	// ----------------------------------------
	// vme master request
	// ----------------------------------------
	// address and modifier latched from the entry at lookup end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			vme_start <= 1'b0;
			vme_addr  <= 32'h00000000;
			vme_am    <= 6'h00;
			vme_asize <= 2'h0;
			vme_fcode <= 2'h0;
			vme_be_n  <= 4'hf;
			vme_write <= 1'b0;
			vme_wdata <= 32'h00000000;
		end else begin
			vme_start <= 1'b0;
			if (state_r == PVOB_LOOK && state_nxt == PVOB_VME) begin
				vme_start <= 1'b1;
				vme_addr  <= {map.rdata[`PVOB_ENT_PAGE_HI:`PVOB_ENT_PAGE_LO], mem_addr[17:2], 2'h0};
				vme_am    <= am_of(map.rdata[`PVOB_ENT_ADDRESS_SIZE_FIELD_HI:`PVOB_ENT_ADDRESS_SIZE_FIELD_LO],
				                   map.rdata[`PVOB_ENT_FC_HI:`PVOB_ENT_FC_LO], user_am);
				vme_asize <= map.rdata[`PVOB_ENT_ADDRESS_SIZE_FIELD_HI:`PVOB_ENT_ADDRESS_SIZE_FIELD_LO];
				vme_fcode <= map.rdata[`PVOB_ENT_FC_HI:`PVOB_ENT_FC_LO];
				vme_be_n  <= mem_be_n;
				vme_write <= mem_wr;
				vme_wdata <= mem_wdata;
			end
		end
	end

	// ----------------------------------------
	// memory answer
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			mem_done  <= 1'b0;
			mem_rdata <= 32'h00000000;
		end else begin
			mem_done <= 1'b0;
			if (map.we) begin
				mem_done <= 1'b1;
			end else if (state_r == PVOB_LOOK && hit_map) begin
				mem_done  <= 1'b1;
				mem_rdata <= map.rdata;
			end else if (state_r == PVOB_VME && vme_done) begin
				mem_done <= 1'b1;
			end else if (state_r == PVOB_ERR) begin
				mem_done <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// error flag and interrupt
	// ----------------------------------------
	// set wins over a clear in the same cycle
	// error flag set
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			err_flag_r <= 1'b0;
		end else if (state_r == PVOB_LOOK && state_nxt == PVOB_ERR) begin
			err_flag_r <= 1'b1;
		end else if (err_clr) begin
			err_flag_r <= 1'b0;
		end
	end
	assign err_flag = err_flag_r;
	assign err_irq = err_flag_r && err_int_en;
endmodule : pvob_bridge
`default_nettype wire

// file: verilog/pvob_regs.svh
// Purpose: offsets, field positions, reset values for the outbound window map
// Assumes: included by bare name from design files
// Notes: definitions only
`ifndef PVOB_REGS_SVH
`define PVOB_REGS_SVH
// ----------------------------------------
// configuration space offsets
// ----------------------------------------
`define PVOB_OFS_CSR_BASE    12'h810
`define PVOB_OFS_LARGE_BASE  12'h814
`define PVOB_OFS_MAP_BASE    12'h818
`define PVOB_OFS_SMALL_BASE  12'h81c
`define PVOB_OFS_SMALL_SIZE  12'h840
// ----------------------------------------
// base register write masks and window size masks
// ----------------------------------------
`define PVOB_CSR_MASK        32'hfffffe00
`define PVOB_LARGE512_MASK   32'he0000000
`define PVOB_LARGE256_MASK   32'hf0000000
`define PVOB_MAP_MASK        32'hfffe0000
`define PVOB_SMALL64_MASK    32'hfc000000
`define PVOB_SMALL32_MASK    32'hfe000000
`define PVOB_SMALL16_MASK    32'hff000000
`define PVOB_SMALL8_MASK     32'hff800000
`define PVOB_BASE_RST        32'h00000000
// ----------------------------------------
// small window size codes
// ----------------------------------------
`define PVOB_SZ_8M           3'h0
`define PVOB_SZ_16M          3'h1
`define PVOB_SZ_32M          3'h3
`define PVOB_SZ_64M          3'h7
// ----------------------------------------
// map entry fields
// ----------------------------------------
`define PVOB_ENT_VALID       5
`define PVOB_ENT_LOW_MBZ     32'hffffffe0
`define PVOB_ENT_PAGE_HI     31
`define PVOB_ENT_PAGE_LO     18
`define PVOB_ENT_ADDRESS_SIZE_FIELD_HI     17
`define PVOB_ENT_ADDRESS_SIZE_FIELD_LO     16
`define PVOB_ENT_FC_HI       15
`define PVOB_ENT_FC_LO       14
// ----------------------------------------
// address modifier bases (data, user)
// ----------------------------------------
`define PVOB_AM_A32          6'h09
`define PVOB_AM_A24          6'h39
`define PVOB_AM_A16          6'h29
`define PVOB_ADDRESS_SIZE_FIELD_USER       2'h0
`define PVOB_ADDRESS_SIZE_FIELD_A32        2'h1
`define PVOB_ADDRESS_SIZE_FIELD_A16        2'h2
`define PVOB_ADDRESS_SIZE_FIELD_A24        2'h3
`endif

// file: verilog/pvob_pkg.sv
// Purpose: types shared by the outbound window map
// Assumes: nothing
// Notes: constants live in pvob_regs.svh
`default_nettype none
package pvob_pkg;
	// lookup state machine, one-hot
	typedef enum logic [3:0] {
		PVOB_IDLE = 4'h1,
		PVOB_LOOK = 4'h2,
		PVOB_VME  = 4'h4,
		PVOB_ERR  = 4'h8
	} pvob_state_t;
endpackage : pvob_pkg
`default_nettype wire

// file: verilog/pvob_map_if.sv
// Purpose: carrier between the bridge top and its map storage
// Assumes: one clock
// Notes: index-addressed entries
`default_nettype none
interface pvob_map_if #(parameter int IDX_W = 11);
	logic             we;     // write strobe
	logic [IDX_W-1:0] widx;   // write index
	logic [31:0]      wdata;  // write data
	logic [IDX_W-1:0] ridx;   // read index
	logic [31:0]      rdata;  // read data, registered
	modport ctrl (output we, widx, wdata, ridx, input rdata);
	modport mem  (input we, widx, wdata, ridx, output rdata);
endinterface : pvob_map_if
`default_nettype wire

// file: verilog/pvob_map_ram.sv
// Purpose: outbound map entry storage in flip-flops
// Assumes: synchronous reset, one clock
// Notes: low five bits never stored, read as zero
`include "pvob_regs.svh"
`default_nettype none
module pvob_map_ram
	import pvob_pkg::*;
#(
	parameter int DEPTH = 2048,  // entries
	parameter int IDX_W = 11     // index width
)(
	input  wire logic sys_clk,   // clock
	input  wire logic reset,     // sync reset, high
	pvob_map_if.mem   m          // map port
);
	// ----------------------------------------
	// storage
	// ----------------------------------------
	logic [31:0] mem_r [DEPTH];  // entries
	// write path, low bits forced to zero
	// upper bits only
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_r[i] <= 32'h00000000;
			end
		end else if (m.we) begin
			mem_r[m.widx] <= m.wdata & `PVOB_ENT_LOW_MBZ;
		end
	end
	// registered read, one cycle latency
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			m.rdata <= 32'h00000000;
		end else begin
			m.rdata <= mem_r[m.ridx];
		end
	end
endmodule : pvob_map_ram
`default_nettype wire

// file: tb/pvob_bridge_monitor.sv
// Purpose: concurrent checks on the outbound window map ports
// Assumes: one clock domain, synchronous reset active high
// Notes: bound to every pvob_bridge instance
`default_nettype none
module pvob_bridge_chk (
	input wire logic        sys_clk,     // clock
	input wire logic        reset,       // sync reset
	input wire logic [1:0]  small_strap, // small size pins
	input wire logic        cfg_req,     // config strobe
	input wire logic        cfg_wr,      // config write
	input wire logic [11:0] cfg_addr,    // config offset
	input wire logic        cfg_ack,     // config answer
	input wire logic [31:0] cfg_rdata,   // config data
	input wire logic [31:0] mem_addr,    // memory address
	input wire logic        mem_hit,     // window hit
	input wire logic        mem_done,    // memory answer
	input wire logic [5:0]  user_am,     // user modifier
	input wire logic        err_int_en,  // irq enable
	input wire logic        err_flag,    // error flag
	input wire logic        err_irq,     // interrupt
	input wire logic        vme_start,   // vme start
	input wire logic [31:0] vme_addr,    // vme address
	input wire logic [5:0]  vme_am,      // modifier
	input wire logic [1:0]  vme_asize,   // size field
	input wire logic [1:0]  vme_fcode,   // function field
	input wire logic        vme_done     // vme answer
);
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// helpers
	// ----------------
	wire        rd  = cfg_req && !cfg_wr; // config read taken
	wire [15:0] ofs = mem_addr[17:2];     // longword within page
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	// modifier expected from size and function fields, user code when size is 00
	function automatic logic [5:0] am_exp(input logic [1:0] sz, input logic [1:0] fc, input logic [5:0] ua);
		case (sz)
			2'h1: am_exp = 6'h09 + {3'h0, fc[1], 1'b0, fc[0]};
			2'h3: am_exp = 6'h39 + {3'h0, fc[1], 1'b0, fc[0]};
			2'h2: am_exp = 6'h29 | {3'h0, fc[1], 2'h0};
			default: am_exp = ua;
		endcase
	endfunction : am_exp
	// ----------------
	// assertions
	// ----------------
	AST_CFG_ACK: assert property (cfg_req |=> cfg_ack)
		else $error("config request not answered");
	AST_ACK_CAUSE: assert property (cfg_ack |-> $past(cfg_req))
		else $error("config answer without request");
	AST_CSR_LOW: assert property (rd && cfg_addr == 12'h810 |=> cfg_rdata[8:0] == 9'h0)
		else $error("csr base low bits not zero");
	AST_LARGE_LOW: assert property (rd && cfg_addr == 12'h814 |=> cfg_rdata[27:0] == 28'h0)
		else $error("large base fixed bits not zero");
	AST_SMALL_LOW: assert property (rd && cfg_addr == 12'h81c |=> cfg_rdata[25:0] == 26'h0)
		else $error("small base fixed bits not zero");
	AST_SIZE_CODE: assert property (rd && cfg_addr == 12'h840 |=>
		cfg_rdata == {29'h0, &small_strap, small_strap[1], |small_strap})
		else $error("small size code wrong");
	AST_IRQ: assert property (err_irq == (err_flag && err_int_en))
		else $error("interrupt does not follow flag and enable");
	AST_ERR_NO_VME: assert property ($rose(err_flag) |-> !vme_start ##1 mem_done)
		else $error("invalid entry started vme or no answer");
	AST_START_HIT: assert property (vme_start |-> $past(mem_hit, 2))
		else $error("vme start without window hit");
	AST_START_OFS: assert property (vme_start |-> vme_addr[17:0] == {$past(ofs, 2), 2'h0})
		else $error("vme offset not from pci address");
	AST_AM: assert property (vme_start |-> vme_am == am_exp(vme_asize, vme_fcode, user_am))
		else $error("address modifier wrong");
	AST_DONE_VME: assert property (vme_done |=> mem_done)
		else $error("vme completion not passed on");
	// main scenarios reached
	COV_VME: cover property (vme_start);
	COV_ERR: cover property ($rose(err_flag));
	COV_IRQ: cover property (err_irq);
endmodule : pvob_bridge_chk
bind pvob_bridge pvob_bridge_chk u_chk (.sys_clk, .reset, .small_strap, .cfg_req, .cfg_wr, .cfg_addr,
	.cfg_ack, .cfg_rdata, .mem_addr, .mem_hit, .mem_done, .user_am, .err_int_en, .err_flag, .err_irq,
	.vme_start, .vme_addr, .vme_am, .vme_asize, .vme_fcode, .vme_done);
`default_nettype wire

// file: tb/pvob_vme_slave.sv
// Purpose: vme slave boards answering outbound master cycles
// Assumes: one clock, vme_start is a one-cycle pulse
// Notes: slow stretches the answer to test a waiting bridge
`default_nettype none
module pvob_vme_slave (
	input  wire logic sys_clk,   // clock
	input  wire logic reset,     // sync reset, high
	input  wire logic slow,      // late answer
	input  wire logic vme_start, // cycle begins
	output logic      vme_done   // one-cycle answer
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] wait_r; // cycles left, zero when idle
	// count down from each start; answers only cycles really started
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wait_r   <= 4'h0;
			vme_done <= 1'b0;
		end else begin
			vme_done <= (wait_r == 4'h1);
			if (vme_start) wait_r <= slow ? 4'h9 : 4'h2;
			else if (wait_r != 4'h0) wait_r <= wait_r - 4'h1;
		end
	end
endmodule : pvob_vme_slave
`default_nettype wire

// file: tb/tb_top.sv
// Purpose: self-checking bench for the outbound window map
// Assumes: one access at a time, windows kept apart
// Notes: far side answered by pvob_vme_slave
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------------
	// signals
	// ----------------
	logic        sys_clk, reset, large_strap, cfg_req, cfg_wr, cfg_ack, mem_req, mem_wr, mem_done, mem_hit;
	logic        err_int_en, err_clr, err_flag, err_irq, vme_start, vme_write, vme_done, slow;
	logic [1:0]  small_strap, vme_asize, vme_fcode;
	logic [3:0]  mem_be_n, vme_be_n;
	logic [5:0]  user_am, vme_am;
	logic [11:0] cfg_addr;
	logic [31:0] cfg_wdata, cfg_rdata, mem_addr, mem_wdata, mem_rdata, vme_addr, vme_wdata, rd;
	int          n_mismatch, n_tests, n_start, k;
	// config rows: offset, value after reset, value after writing all ones
	localparam logic [75:0] ROWS [6] = '{{12'h810, 32'h0, 32'hfffffe00}, {12'h814, 32'h0, 32'he0000000},
		{12'h818, 32'h0, 32'hfffe0000}, {12'h81c, 32'h0, 32'hfc000000}, {12'h840, 32'h7, 32'h7},
		{12'h844, 32'h0, 32'h0}};
	// map rows: expected modifier, entry (page, size, function, valid)
	localparam logic [37:0] VROW [4] = '{{6'h0d, 14'h0aa1, 2'h1, 2'h2, 8'h0, 1'b1, 5'h0},
		{6'h3a, 14'h1234, 2'h3, 2'h1, 8'h0, 1'b1, 5'h0}, {6'h2d, 14'h0003, 2'h2, 2'h2, 8'h0, 1'b1, 5'h0},
		{6'h15, 14'h3ff0, 2'h0, 2'h3, 8'h0, 1'b1, 5'h0}};
	pvob_bridge uut (.sys_clk, .reset, .large_strap, .small_strap, .cfg_req, .cfg_wr, .cfg_addr, .cfg_wdata,
		.cfg_ack, .cfg_rdata, .mem_req, .mem_wr, .mem_addr, .mem_be_n, .mem_wdata, .mem_done, .mem_rdata,
		.mem_hit, .user_am, .err_int_en, .err_clr, .err_flag, .err_irq, .vme_start, .vme_addr, .vme_am,
		.vme_asize, .vme_fcode, .vme_be_n, .vme_write, .vme_wdata, .vme_done);
	pvob_vme_slave u_slave (.sys_clk, .reset, .slow, .vme_start, .vme_done);
	always #12.5 sys_clk = ~sys_clk;
	// count started vme cycles, read before this edge's updates land
	always @(posedge sys_clk) begin
		if (vme_start === 1'b1) n_start++;
	end
	// ----------------
	// tasks
	// ----------------
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : complete_run
	// one config cycle, answer expected one cycle later
	task automatic cfg(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		cfg_req   <= 1'b1;
		cfg_wr    <= wr;
		cfg_addr  <= a;
		cfg_wdata <= d;
		@(posedge sys_clk);
		cfg_req <= 1'b0;
		@(negedge sys_clk);
		chk("cfg_ack", {31'h0, cfg_ack}, 32'h1);
		rd = cfg_rdata;
	endtask : cfg
	// memory cycle held until done, released at the edge that samples done
	task automatic mem(input logic wr, input logic [31:0] a, input logic [3:0] be, input logic [31:0] d);
		int i;
		@(posedge sys_clk);
		mem_req   <= 1'b1;
		mem_wr    <= wr;
		mem_addr  <= a;
		mem_be_n  <= be;
		mem_wdata <= d;
		for (i = 0; i < 40; i++) begin
			@(negedge sys_clk);
			if (mem_done === 1'b1) break;
		end
		if (i == 40) begin
			n_mismatch++;
			complete_run();
		end
		rd = mem_rdata;
		@(posedge sys_clk);
		mem_req <= 1'b0;
	endtask : mem
	// an address outside every window is never claimed
	task automatic miss(input logic [31:0] a);
		k = n_start;
		@(posedge sys_clk);
		mem_req  <= 1'b1;
		mem_addr <= a;
		repeat (6) @(negedge sys_clk);
		chk("miss", {31'h0, mem_hit} + n_start - k, 32'h0);
		@(posedge sys_clk);
		mem_req <= 1'b0;
	endtask : miss
	// ----------------
	// main sequence
	// ----------------
	initial begin
		{sys_clk, cfg_req, cfg_wr, mem_req, mem_wr, err_int_en, err_clr, slow} = 8'h0;
		{reset, large_strap, small_strap} = 4'hf;
		{cfg_addr, cfg_wdata, mem_addr, mem_wdata} = 108'h0;
		{mem_be_n, user_am} = 10'h015;
		n_mismatch = 0;
		n_tests = 0;
		n_start = 0;
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		@(negedge sys_clk);
		chk("reset outs", {24'h0, vme_be_n, err_flag, vme_start, mem_done, cfg_ack}, 32'hf0);
		foreach (ROWS[i]) begin
			cfg(1'b0, ROWS[i][75:64], 32'h0);
			chk("reset value", rd, ROWS[i][63:32]);
			cfg(1'b1, ROWS[i][75:64], 32'hffffffff);
			cfg(1'b0, ROWS[i][75:64], 32'h0);
			chk("read back", rd, ROWS[i][31:0]);
		end
		cfg(1'b1, 12'h810, 32'h00100000);
		cfg(1'b1, 12'h814, 32'h20000000);
		cfg(1'b1, 12'h818, 32'h00200000);
		cfg(1'b1, 12'h81c, 32'h04000000);
		miss(32'h00000810);
		// every strap setting: size code and first address past the window
		for (int s = 0; s < 4; s++) begin
			@(posedge sys_clk);
			small_strap <= s[1:0];
			cfg(1'b0, 12'h840, 32'h0);
			chk("size code", rd, 32'h7 >> (3 - s));
			miss(32'h04000000 + (32'h00800000 << s));
		end
		@(posedge sys_clk);
		large_strap <= 1'b0;
		miss(32'h30000000);
		@(posedge sys_clk);
		large_strap <= 1'b1;
		mem(1'b1, 32'h0020001c, 4'h0, 32'hffffffff);
		mem(1'b0, 32'h0020001c, 4'h0, 32'h0);
		chk("entry bits", rd, 32'hffffffe0);
		foreach (VROW[i]) begin
			mem(1'b1, 32'h00200000 + 32'(i + 1) * 4, 4'h0, VROW[i][31:0]);
			slow <= i[0];
			mem(i[0], 32'h20000000 + (32'(i + 1) << 18) + 32'h00012344, 4'(i), 32'hc0de0000 + 32'(i));
			chk("vme count", n_start, i + 1);
			chk("vme addr", vme_addr, {VROW[i][31:18], 18'h12344});
			chk("vme am", {26'h0, vme_am}, {26'h0, VROW[i][37:32]});
			chk("vme fields", {24'h0, vme_asize, vme_fcode, vme_be_n}, {24'h0, VROW[i][17:14], 4'(i)});
			chk("vme dir", {31'h0, vme_write}, {31'h0, i[0]});
			if (i[0]) chk("vme data", vme_wdata, 32'hc0de0000 + 32'(i));
		end
		mem(1'b0, 32'h04052344, 4'h0, 32'h0);
		chk("alias addr", vme_addr, {VROW[0][31:18], 18'h12344});
		mem(1'b1, 32'h00201ffc, 4'h0, {14'h2ace, 4'h4, 8'h0, 6'h20});
		mem(1'b0, 32'h3ffc0000, 4'h0, 32'h0);
		chk("last page", {vme_addr[31:18], 12'h0, vme_am}, {14'h2ace, 12'h0, 6'h09});
		k = n_start;
		mem(1'b0, 32'h20180000, 4'h0, 32'h0);
		chk("err set", {30'h0, err_flag, err_irq} + n_start - k, 32'h2);
		@(posedge sys_clk);
		err_int_en <= 1'b1;
		@(negedge sys_clk);
		chk("irq on", {31'h0, err_irq}, 32'h1);
		@(posedge sys_clk);
		err_clr <= 1'b1;
		@(posedge sys_clk);
		err_clr <= 1'b0;
		@(negedge sys_clk);
		chk("err clear", {30'h0, err_flag, err_irq}, 32'h0);
		complete_run();
	end
endmodule : tb_top
`default_nettype wire
